// File: dv/test_file_register_move_logic_ops.sv
`timescale 1ns/1ns
module test_file_register_move_logic_ops
   import fro_pkg::*;
;
   logic      MCLK = 0, NRST = 0, OP_VALID = 0, DEST_SEL = 0;
   fro_op_t   OP_CODE = FRO_NOP_OP;
   fro_addr_t FILE_ADDR = 0, PEEK_ADDR = 0;
   fro_data_t LITERAL = 0;
   fro_data_t PEEK_DATA, ACCUM, m_acc, e_peek, m_file[128];
   logic      ZERO_FLAG, PC_ADVANCE, m_zero, e_pc;
   int        n_mismatch = 0, compares = 0;

   fro_datapath i_dut (.MCLK(MCLK), .NRST(NRST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
      .FILE_ADDR(FILE_ADDR), .DEST_SEL(DEST_SEL), .LITERAL(LITERAL), .PEEK_ADDR(PEEK_ADDR),
      .PEEK_DATA(PEEK_DATA), .ACCUM(ACCUM), .ZERO_FLAG(ZERO_FLAG), .PC_ADVANCE(PC_ADVANCE));

   always #10 MCLK = ~MCLK;

   // ------------------------------------------------------------
   // Checking and verdict
   // ------------------------------------------------------------
   task check(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : check

   task results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   function fro_data_t calc(fro_op_t op, fro_data_t acc, fro_data_t f);
      return (op == FRO_INCREMENT_FILE_OP) ? f + 8'h01 : (op == FRO_OR_ACCUM_WITH_FILE_OP) ? (acc | f) : f;
   endfunction : calc

   // One op per cycle, driven at the falling edge, checked at the next one
   task step(logic v, fro_op_t op, fro_addr_t a, logic d, fro_data_t k, fro_addr_t pa);
      fro_data_t r;
      OP_VALID = v;
      OP_CODE = op;
      FILE_ADDR = a;
      DEST_SEL = d;
      // Literal is a full byte, no don't-care bits reach the block
      LITERAL = k;
      PEEK_ADDR = pa;
      e_peek = m_file[pa];
      e_pc = v;
      r = calc(op, m_acc, m_file[a]);
      if (v && (op == FRO_INCREMENT_FILE_OP || op == FRO_OR_ACCUM_WITH_FILE_OP || op == FRO_MOVE_FILE_OP)) begin
         m_zero = (r == 8'h00);
         if (d) m_file[a] = r;
         else m_acc = r;
      end
      if (v && op == FRO_STORE_ACCUM_OP) m_file[a] = m_acc;
      if (v && op == FRO_LOAD_LITERAL_OP) m_acc = k;
      @(negedge MCLK);
      check("ACCUM", m_acc, ACCUM);
      check("ZERO_FLAG", {7'h00, m_zero}, {7'h00, ZERO_FLAG});
      check("PEEK_DATA", e_peek, PEEK_DATA);
      check("PC_ADVANCE", {7'h00, e_pc}, {7'h00, PC_ADVANCE});
   endtask : step

   function fro_addr_t raddr();
      return fro_addr_t'($urandom_range(0, 9)) + (($urandom % 2) ? 7'h76 : 7'h00);
   endfunction : raddr

   initial begin
      #100000;
      n_mismatch++;
      results();
   end

   initial begin
      foreach (m_file[i]) m_file[i] = 8'h00;
      m_acc = 8'h00;
      m_zero = 1'b0;
      void'($urandom(58));
      repeat (4) @(posedge MCLK);
      @(negedge MCLK);
      NRST = 1;
      check("ACCUM", 8'h00, ACCUM);
      // Corner cases: top address, wrap to zero, flags held by load
      step(1, FRO_LOAD_LITERAL_OP, 0, 1, 8'hFF, 0);
      step(1, FRO_STORE_ACCUM_OP, 127, 0, 0, 127);
      step(1, FRO_INCREMENT_FILE_OP, 127, 1, 0, 127);
      step(1, FRO_MOVE_FILE_OP, 127, 0, 0, 127);
      step(1, FRO_LOAD_LITERAL_OP, 0, 0, 8'h05, 127);
      step(1, FRO_NOP_OP, 127, 1, 8'hAA, 127);
      step(0, FRO_STORE_ACCUM_OP, 127, 1, 0, 127);
      step(1, FRO_OR_ACCUM_WITH_FILE_OP, 127, 1, 0, 127);
      repeat (2000) begin
         step($urandom % 8 != 0, fro_op_t'($urandom_range(0, 5)), raddr(), $urandom % 2,
              fro_data_t'($urandom_range(0, 255)), raddr());
      end
      // Mid-run reset must clear every register, including written file entries
      NRST = 0;
      OP_VALID = 0;
      @(negedge MCLK);
      check("ACCUM", 8'h00, ACCUM);
      check("ZERO_FLAG", 8'h00, {7'h00, ZERO_FLAG});
      check("PC_ADVANCE", 8'h00, {7'h00, PC_ADVANCE});
      check("PEEK_DATA", 8'h00, PEEK_DATA);
      foreach (m_file[i]) m_file[i] = 8'h00;
      m_acc = 8'h00;
      m_zero = 1'b0;
      NRST = 1;
      step(1, FRO_LOAD_LITERAL_OP, 0, 0, 8'h3C, 0);
      for (int i = 0; i < 128; i++) begin
         step(0, FRO_NOP_OP, 0, 0, 8'h00, fro_addr_t'(i));
      end
      results();
   end
endmodule : test_file_register_move_logic_ops

// File: hw/fro_datapath.sv
`timescale 1ns/1ns
`include "fro_params.svh"

module fro_datapath
   import fro_pkg::*;
(
   input  wire logic      MCLK,
   input  wire logic      NRST,
   input  wire logic      OP_VALID,
   input  wire fro_op_t   OP_CODE,
   input  wire fro_addr_t FILE_ADDR,
   input  wire logic      DEST_SEL,
   input  wire fro_data_t LITERAL,
   input  wire fro_addr_t PEEK_ADDR,
   output fro_data_t      PEEK_DATA,
   output fro_data_t      ACCUM,
   output logic           ZERO_FLAG,
   output logic           PC_ADVANCE
);

   // ---------------------------------------------------------
   // State
   // ---------------------------------------------------------
   fro_data_t accum_reg;
   fro_data_t accum_next;
   logic      zero_reg;
   logic      zero_next;
   logic      adv_reg;
   fro_data_t peek_reg;

   // ---------------------------------------------------------
   // Decode
   // ---------------------------------------------------------
   wire logic      is_inc   = OP_VALID && (OP_CODE == FRO_INCREMENT_FILE_OP);
   wire logic      is_or    = OP_VALID && (OP_CODE == FRO_OR_ACCUM_WITH_FILE_OP);
   wire logic      is_move  = OP_VALID && (OP_CODE == FRO_MOVE_FILE_OP);
   wire logic      is_store = OP_VALID && (OP_CODE == FRO_STORE_ACCUM_OP);
   wire logic      is_lit   = OP_VALID && (OP_CODE == FRO_LOAD_LITERAL_OP);
   wire logic      has_dest = is_inc || is_or || is_move;
   wire logic      to_file  = has_dest && (DEST_SEL == `FRO_DEST_FILE);
   wire logic      to_accum = has_dest && (DEST_SEL == `FRO_DEST_ACCUM);
   wire fro_data_t file_rd;
   wire fro_data_t peek_rd;

   // ---------------------------------------------------------
   // Result selection
   // ---------------------------------------------------------
   // Increment sum
   wire fro_data_t inc_res  = fro_data_t'(file_rd + `FRO_INC_STEP);
   wire fro_data_t or_res   = accum_reg | file_rd;
   wire fro_data_t alu_res  = is_inc ? inc_res : (is_or ? or_res : file_rd);
   wire logic      res_zero = (alu_res == `FRO_ZERO_VAL);

   wire logic      file_we    = to_file || is_store;
   wire fro_data_t file_wdata = is_store ? accum_reg : alu_res;

   assign accum_next = to_accum ? alu_res : (is_lit ? LITERAL : accum_reg);
   // Zero flag follows only result-producing ops
   assign zero_next  = has_dest ? res_zero : zero_reg;

   fro_file_regs u_file (
      .clk       (MCLK),
      .rst_n     (NRST),
      .wr_en     (file_we),
      .wr_addr   (FILE_ADDR),
      .wr_data   (file_wdata),
      .rd_addr   (FILE_ADDR),
      .rd_data   (file_rd),
      .peek_addr (PEEK_ADDR),
      .peek_data (peek_rd)
   );

   // ---------------------------------------------------------
   // Registers
   // ---------------------------------------------------------
   // Every operation completes in one cycle
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         accum_reg <= `FRO_ACCUM_RST;
         zero_reg  <= `FRO_ZERO_RST;
         adv_reg   <= `FRO_ADV_RST;
         peek_reg  <= `FRO_FILE_RST;
      end else begin
         accum_reg <= accum_next;
         zero_reg  <= zero_next;
         adv_reg   <= OP_VALID;
         peek_reg  <= peek_rd;
      end
   end

   assign ACCUM      = accum_reg;
   assign ZERO_FLAG  = zero_reg;
   assign PC_ADVANCE = adv_reg;
   assign PEEK_DATA  = peek_reg;

   // ---------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------
   AST_DEST_ACCUM: assert property (
      @(posedge MCLK) disable iff (!NRST)
      to_accum |-> !file_we ##1 (ACCUM == $past(alu_res)))
      else $error("Accumulator destination did not receive result");

   AST_DEST_FILE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      to_file |-> file_we && (file_wdata == alu_res) ##1 $stable(ACCUM))
      else $error("File destination mishandled");

   AST_INC_SUM: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_inc && to_accum |=> ACCUM == fro_data_t'($past(file_rd) + `FRO_INC_STEP))
      else $error("Increment result wrong");

   AST_INC_ZERO: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_inc && (&file_rd) |=> ZERO_FLAG)
      else $error("Increment wrap did not set zero flag");

   AST_OR_RESULT: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_or && to_accum |=> ACCUM == ($past(accum_reg) | $past(file_rd)))
      else $error("OR result wrong");

   AST_MOVE_ZERO: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_move |=> (ZERO_FLAG == ($past(file_rd) == `FRO_ZERO_VAL)) && PC_ADVANCE)
      else $error("Move zero flag or timing wrong");

   AST_STORE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_store |-> file_we && (file_wdata == accum_reg) ##1 $stable(ZERO_FLAG) && $stable(ACCUM))
      else $error("Store wrote wrong value or touched flags");

   AST_LITERAL: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_lit |=> (ACCUM == $past(LITERAL)) && $stable(ZERO_FLAG) && PC_ADVANCE)
      else $error("Literal load wrong");

   AST_NOP: assert property (
      @(posedge MCLK) disable iff (!NRST)
      OP_VALID && (OP_CODE == FRO_NOP_OP) |-> !file_we ##1 $stable(ACCUM) && $stable(ZERO_FLAG) && PC_ADVANCE)
      else $error("No-operation changed state");

   AST_INC_FILE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_inc && to_file |-> file_we && (file_wdata == fro_data_t'(file_rd + `FRO_INC_STEP)))
      else $error("Increment to file register wrote wrong value");

   AST_INC_NONZERO: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_inc && !(&file_rd) |=> !ZERO_FLAG)
      else $error("Increment set zero flag on a nonzero sum");

   AST_OR_FILE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_or && to_file |-> file_we && (file_wdata == (accum_reg | file_rd)) ##1 $stable(ACCUM))
      else $error("OR to file register mishandled");

   AST_OR_ZERO: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_or |=> ZERO_FLAG == (($past(accum_reg) | $past(file_rd)) == `FRO_ZERO_VAL))
      else $error("OR zero flag wrong");

   AST_MOVE_ACCUM: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_move && to_accum |=> ACCUM == $past(file_rd))
      else $error("Move to accumulator wrong");

   AST_MOVE_FILE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_move && to_file |-> file_we && (file_wdata == file_rd))
      else $error("Move in place changed the file register");

   // Moving a register onto itself is the in-place test: flag only, accumulator kept
   AST_MOVE_TEST: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_move && to_file |=> (ZERO_FLAG == ($past(file_rd) == `FRO_ZERO_VAL)) && $stable(ACCUM))
      else $error("In-place move test wrong");

   AST_STORE_ADV: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_store |=> PC_ADVANCE)
      else $error("Store did not complete in one cycle");

   AST_LIT_NO_WRITE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_lit |-> !file_we)
      else $error("Literal load wrote a file register");

   AST_FLAGS_HELD: assert property (
      @(posedge MCLK) disable iff (!NRST)
      OP_VALID && !has_dest |=> $stable(ZERO_FLAG))
      else $error("Flag changed by an operation that must leave it");

   AST_ACCUM_HELD: assert property (
      @(posedge MCLK) disable iff (!NRST)
      !to_accum && !is_lit |=> $stable(ACCUM))
      else $error("Accumulator changed without an accumulator destination");

   // Idle cycles must hold the accumulator, zero flag and file registers and must not advance the counter
   AST_IDLE_HOLD: assert property (
      @(posedge MCLK) disable iff (!NRST)
      !OP_VALID |-> !file_we ##1 $stable(ACCUM) && $stable(ZERO_FLAG) && !PC_ADVANCE)
      else $error("Idle cycle changed state");

   AST_PC_ONE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      OP_VALID |=> PC_ADVANCE)
      else $error("Counter advance missing after an operation");

   AST_INC_ONE_CYCLE: assert property (
      @(posedge MCLK) disable iff (!NRST)
      is_inc |=> PC_ADVANCE)
      else $error("Increment did not complete in one cycle");

endmodule : fro_datapath

// File: hw/fro_file_regs.sv
`timescale 1ns/1ns
`include "fro_params.svh"

module fro_file_regs
   import fro_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      wr_en,
   input  wire fro_addr_t wr_addr,
   input  wire fro_data_t wr_data,
   input  wire fro_addr_t rd_addr,
   output fro_data_t      rd_data,
   input  wire fro_addr_t peek_addr,
   output fro_data_t      peek_data
);

   // ---------------------------------------------------------
   // Storage, one flop group per entry
   // ---------------------------------------------------------
   fro_data_t mem_reg [`FRO_DEPTH];

   genvar gi;
   generate
      for (gi = 0; gi < `FRO_DEPTH; gi = gi + 1) begin : g_entry
         wire fro_addr_t entry_addr = fro_addr_t'(gi);
         wire logic      hit        = wr_en && (wr_addr == entry_addr);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_reg[gi] <= `FRO_FILE_RST;
            end else if (hit) begin
               mem_reg[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // Reads are combinational so an operation completes in one cycle
   assign rd_data   = mem_reg[rd_addr];
   assign peek_data = mem_reg[peek_addr];

endmodule : fro_file_regs

// File: hw/fro_params.svh
`ifndef FRO_PARAMS_SVH
`define FRO_PARAMS_SVH

// ------------------------------------------------------------
// Widths and depth
// ------------------------------------------------------------
`define FRO_ADDR_W      7
`define FRO_DATA_W      8
`define FRO_DEPTH       128

// ------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------
`define FRO_ACCUM_RST   8'h00
`define FRO_FILE_RST    8'h00
`define FRO_ADDR_RST    7'h00
`define FRO_ZERO_RST    1'b0
`define FRO_ADV_RST     1'b0
`define FRO_INC_STEP    8'h01
`define FRO_ZERO_VAL    8'h00

// ------------------------------------------------------------
// Destination selector encoding
// ------------------------------------------------------------
`define FRO_DEST_ACCUM  1'b0
`define FRO_DEST_FILE   1'b1

`endif

// File: hw/fro_pkg.sv
`include "fro_params.svh"

package fro_pkg;

   // ---------------------------------------------------------
   // Operation select
   // ---------------------------------------------------------
   typedef enum logic [2:0] {
      FRO_NOP_OP,
      FRO_INCREMENT_FILE_OP,
      FRO_OR_ACCUM_WITH_FILE_OP,
      FRO_MOVE_FILE_OP,
      FRO_STORE_ACCUM_OP,
      FRO_LOAD_LITERAL_OP
   } fro_op_t;

   typedef logic [`FRO_DATA_W-1:0] fro_data_t;
   typedef logic [`FRO_ADDR_W-1:0] fro_addr_t;

endpackage : fro_pkg
